// ==== hdl/mbe_defs.svh ====
/*
  Constants for the mode, banking and exception unit: status word layout,
  vectors, reset values and physical register numbering.
  Assumes it is included by bare name from the core module.
*/
`ifndef MBE_DEFS_SVH
`define MBE_DEFS_SVH

// Status word bit positions inside register fifteen
`define MBE_BIT_N 31
`define MBE_BIT_Z 30
`define MBE_BIT_C 29
`define MBE_BIT_V 28
`define MBE_BIT_I 27
`define MBE_BIT_F 26
`define MBE_PC_HI 25
`define MBE_PC_LO 2

// Status bits a user-mode write may touch: N Z C V only
`define MBE_USER_FLAG_MASK 32'hF000_0000
// Program counter field mask
`define MBE_PC_MASK 32'h03FF_FFFC
// Mode and interrupt-mask field mask
`define MBE_PRIV_MASK 32'h0C00_0003

// Exception vectors (byte addresses)
`define MBE_VEC_ADDR_EXC 26'h000_0014
`define MBE_VEC_IRQ 26'h000_0018
`define MBE_VEC_FIQ 26'h000_001C

// Reset: supervisor mode, both masks set, program counter zero
`define MBE_R15_RESET 32'h0C00_0003

// Physical register numbering of the banked copies
`define MBE_PHYS_FIQ_BASE 5'h0F
`define MBE_PHYS_IRQ_R13 5'h16
`define MBE_PHYS_IRQ_R14 5'h17
`define MBE_PHYS_SVC_R13 5'h18
`define MBE_PHYS_SVC_R14 5'h19
// Physical registers in the array; register fifteen is held apart
`define MBE_PHYS_COUNT 26

`endif

// ==== hdl/mbe_pkg.sv ====
/*
  Types for the mode, banking and exception unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mbe_pkg;

  // Mode as held in the low two status bits
  typedef enum logic [1:0] {
    MBE_MODE_USER = 2'h0,
    MBE_MODE_FIQ = 2'h1,
    MBE_MODE_IRQ = 2'h2,
    MBE_MODE_SVC = 2'h3
  } mbe_mode_t;

  // Kind of memory transfer being checked
  typedef enum logic [1:0] {
    MBE_XF_SINGLE = 2'h0,
    MBE_XF_BLOCK = 2'h1,
    MBE_XF_BRANCH = 2'h2
  } mbe_xfer_t;

endpackage : mbe_pkg

// ==== hdl/mbe_core.sv ====
/*
  Mode, register banking and exception entry of a 32-bit core with a
  26-bit address space. Holds the 27 physical registers, steers the banked
  copies from the current mode, samples both interrupt pins at instruction
  boundaries and checks data-transfer addresses.
  Assumes the datapath drives one request at a time, pulses instr_boundary
  once per completed instruction, and that interrupt pins are asynchronous.
*/
// Functional notes
// RULE1 - 32-bit data, 26-bit address out; word accesses aligned to four bytes.
// RULE2 - Stored word puts its least significant byte at the lowest address.
// RULE3 - 27 physical registers; mode selects which 16 are visible.
// RULE4 - Register fifteen holds program counter and status flags, accessible apart.
// RULE5 - Branch-with-link copies register fifteen into the current mode's fourteen.
// RULE6 - Fast-interrupt mode banks registers eight to fourteen privately.
// RULE7 - Normal-interrupt mode banks registers thirteen and fourteen privately.
// RULE8 - Supervisor mode banks registers thirteen and fourteen privately.
// RULE9 - User writes change only N, Z, C, V flags.
// RULE10 - Privileged modes may write every status flag including masks and mode.
// RULE11 - Fast request sampled low at instruction end unless its mask set.
// RULE12 - Fast outranks normal; fast entry also masks normal interrupts.
// RULE13 - Normal request sampled low at instruction end unless its mask set.
// RULE14 - Data address with any of top six bits set traps.
// RULE15 - Branches never trap; block transfers check only the first word.
// RULE16 - Translate hint low in user mode or supervisor forced single transfer.
// RULE17 - Inverted mode outputs: 11 user, 10 fast, 01 normal, 00 supervisor.
// RULE18 - Normal entry saves R15 to its R14, sets I, vectors to 0x18.
// RULE19 - Fast entry saves R15 to its R14, sets I and F, vectors 0x1C.
// RULE20 - Address exception saves R15 to supervisor R14, sets I, vectors 0x14.
// RULE21 - Both interrupts pending: fast taken first, normal stays pending.
// RULE22 - Bank selection is combinational from mode and index.
`timescale 1ns/1ps
`include "mbe_defs.svh"

module mbe_core (
  input wire logic clk_sys, // Core clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic fiq_req_n, // Fast interrupt pin, asynchronous, active low
  input wire logic irq_req_n, // Normal interrupt pin, asynchronous, active low
  input wire logic instr_boundary, // Pulse: an instruction has just completed
  input wire logic [3:0] rd_idx, // Visible register to read
  output logic [31:0] rd_data, // Read data, one cycle after rd_idx
  input wire logic wr_en, // Write the visible register wr_idx
  input wire logic [3:0] wr_idx, // Visible register to write
  input wire logic [31:0] wr_data, // Write data
  input wire logic wr_pc_sel, // For index fifteen: update the program counter
  input wire logic wr_psr_sel, // For index fifteen: update the status flags
  input wire logic link_en, // Branch-with-link: copy fifteen into fourteen
  input wire logic xfer_valid, // A transfer address is presented
  input wire mbe_pkg::mbe_xfer_t xfer_kind, // Single, block or branch
  input wire logic xfer_first, // First word of a block transfer
  input wire logic xfer_byte, // Byte access; otherwise a word
  input wire logic xfer_force_translate_hint_n, // Force-translate bit of a single transfer
  input wire logic [31:0] xfer_addr, // Calculated 32-bit address
  input wire logic [31:0] store_word, // Word to be stored
  output logic [25:0] addr_out, // Address driven to memory
  output logic [31:0] store_lanes, // Store word laid out by byte address
  output logic [7:0] store_byte, // Byte at the addressed lane
  output logic exc_taken, // Pulse: an exception was entered
  output logic [25:0] exc_vector, // Vector of the last exception entered
  output logic [31:0] status_flags, // Register fifteen: flags, mode, pc
  output logic [1:0] mode_code_out_n, // Inverted mode bits
  output logic translate_hint_n // Low while addresses should be translated
);

  logic [31:0] phys_q [0:`MBE_PHYS_COUNT-1];
  logic [31:0] r15_q;
  logic [31:0] r15_d;
  logic [31:0] rd_data_q;
  logic [25:0] addr_out_q;
  logic [31:0] store_lanes_q;
  logic [7:0] store_byte_q;
  logic exc_taken_q;
  logic [25:0] exc_vector_q;
  logic [1:0] mode_n_q;
  logic translate_hint_n_n_q;
  logic [2:0] fiq_sync_q;
  logic [2:0] irq_sync_q;
  logic fiq_lvl_q;
  logic irq_lvl_q;
  mbe_pkg::mbe_mode_t mode;
  mbe_pkg::mbe_mode_t mode_d;
  logic addr_fault;
  logic take_fiq;
  logic take_irq;
  logic [4:0] link_phys;
  logic [4:0] wr_phys;

  // Map a visible index to its physical slot for a given mode
  function automatic logic [4:0] bank_map(input mbe_pkg::mbe_mode_t m, input logic [3:0] idx);
    logic [4:0] p;
    p = {1'b0, idx};
    case (m)
      mbe_pkg::MBE_MODE_FIQ:
      begin
        if (idx >= 4'h8 && idx <= 4'hE)
        begin
          p = `MBE_PHYS_FIQ_BASE + {2'b00, idx[2:0]}; // see RULE6
        end
      end
      mbe_pkg::MBE_MODE_IRQ:
      begin
        if (idx == 4'hD)
        begin
          p = `MBE_PHYS_IRQ_R13; // see RULE7
        end
        else if (idx == 4'hE)
        begin
          p = `MBE_PHYS_IRQ_R14; // see RULE7
        end
      end
      mbe_pkg::MBE_MODE_SVC:
      begin
        if (idx == 4'hD)
        begin
          p = `MBE_PHYS_SVC_R13; // see RULE8
        end
        else if (idx == 4'hE)
        begin
          p = `MBE_PHYS_SVC_R14; // see RULE8
        end
      end
      default:
      begin
        p = {1'b0, idx};
      end
    endcase
    return p;
  endfunction : bank_map

  assign mode = mbe_pkg::mbe_mode_t'(r15_q[1:0]);

  // Trap on any of the top six address bits; branches and later block words are exempt
  assign addr_fault = xfer_valid && (xfer_kind != mbe_pkg::MBE_XF_BRANCH)
    && (xfer_kind == mbe_pkg::MBE_XF_SINGLE || xfer_first)
    && (|xfer_addr[31:26]); // see RULE14 see RULE15

  // Address exception outranks both interrupts; fast outranks normal
  assign take_fiq = instr_boundary && !addr_fault && !r15_q[`MBE_BIT_F] && !fiq_lvl_q; // see RULE11 see RULE21
  assign take_irq = instr_boundary && !addr_fault && !take_fiq
    && !r15_q[`MBE_BIT_I] && !irq_lvl_q; // see RULE12 see RULE13 see RULE21

  // Banked slot chosen straight from the current mode, no pipeline delay
  assign wr_phys = bank_map(mode, wr_idx); // see RULE22
  assign link_phys = addr_fault ? `MBE_PHYS_SVC_R14 :
    take_fiq ? bank_map(mbe_pkg::MBE_MODE_FIQ, 4'hE) :
    take_irq ? `MBE_PHYS_IRQ_R14 : bank_map(mode, 4'hE);

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fiq_sync_q <= 3'h7;
      irq_sync_q <= 3'h7;
      fiq_lvl_q <= 1'b1;
      irq_lvl_q <= 1'b1;
    end
    else
    begin
      fiq_sync_q <= {fiq_sync_q[1:0], fiq_req_n};
      irq_sync_q <= {irq_sync_q[1:0], irq_req_n};
      if (fiq_sync_q[1] == fiq_sync_q[2])
      begin
        fiq_lvl_q <= fiq_sync_q[2];
      end
      if (irq_sync_q[1] == irq_sync_q[2])
      begin
        irq_lvl_q <= irq_sync_q[2];
      end
    end
  end

  // Next value of register fifteen: exception entry beats any instruction write
  always_comb
  begin
    r15_d = r15_q;
    mode_d = mode;
    if (addr_fault)
    begin
      r15_d[1:0] = mbe_pkg::MBE_MODE_SVC; // see RULE20
      r15_d[`MBE_BIT_I] = 1'b1;
      r15_d[`MBE_PC_HI:`MBE_PC_LO] = 24'(`MBE_VEC_ADDR_EXC >> 2);
    end
    else if (take_fiq)
    begin
      r15_d[1:0] = mbe_pkg::MBE_MODE_FIQ; // see RULE19 see RULE12
      r15_d[`MBE_BIT_I] = 1'b1;
      r15_d[`MBE_BIT_F] = 1'b1;
      r15_d[`MBE_PC_HI:`MBE_PC_LO] = 24'(`MBE_VEC_FIQ >> 2);
    end
    else if (take_irq)
    begin
      r15_d[1:0] = mbe_pkg::MBE_MODE_IRQ; // see RULE18
      r15_d[`MBE_BIT_I] = 1'b1;
      r15_d[`MBE_PC_HI:`MBE_PC_LO] = 24'(`MBE_VEC_IRQ >> 2);
    end
    else if (wr_en && wr_idx == 4'hF)
    begin
      if (wr_pc_sel)
      begin
        r15_d = (r15_d & ~`MBE_PC_MASK) | (wr_data & `MBE_PC_MASK); // see RULE4
      end
      if (wr_psr_sel && mode == mbe_pkg::MBE_MODE_USER)
      begin
        r15_d = (r15_d & ~`MBE_USER_FLAG_MASK) | (wr_data & `MBE_USER_FLAG_MASK); // see RULE9
      end
      else if (wr_psr_sel)
      begin
        r15_d = (r15_d & ~(`MBE_USER_FLAG_MASK | `MBE_PRIV_MASK))
          | (wr_data & (`MBE_USER_FLAG_MASK | `MBE_PRIV_MASK)); // see RULE10
      end
    end
    mode_d = mbe_pkg::mbe_mode_t'(r15_d[1:0]);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      r15_q <= `MBE_R15_RESET;
    end
    else
    begin
      r15_q <= r15_d;
    end
  end

  // Banked array: entries save the old register fifteen, link copies it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `MBE_PHYS_COUNT; i++)
      begin
        phys_q[i] <= 32'h0000_0000;
      end
    end
    else if (addr_fault || take_fiq || take_irq || link_en)
    begin
      phys_q[link_phys] <= r15_q; // see RULE5 see RULE18 see RULE19 see RULE20
    end
    else if (wr_en && wr_idx != 4'hF)
    begin
      phys_q[wr_phys] <= wr_data; // see RULE3
    end
  end

  // Visible read; slot fifteen is the combined program counter and flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_data_q <= 32'h0000_0000;
    end
    else if (rd_idx == 4'hF)
    begin
      rd_data_q <= r15_q; // see RULE4
    end
    else
    begin
      rd_data_q <= phys_q[bank_map(mode, rd_idx)]; // see RULE3 see RULE22
    end
  end

  // Memory-facing address and store lanes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      addr_out_q <= 26'h000_0000;
      store_lanes_q <= 32'h0000_0000;
      store_byte_q <= 8'h00;
    end
    else if (xfer_valid && !addr_fault && xfer_kind != mbe_pkg::MBE_XF_BRANCH)
    begin
      // Word accesses drop the low two bits so they stay aligned
      addr_out_q <= xfer_byte ? xfer_addr[25:0] : {xfer_addr[25:2], 2'b00}; // see RULE1
      store_lanes_q <= store_word; // see RULE2
      store_byte_q <= store_word[{xfer_addr[1:0], 3'b000} +: 8]; // see RULE2
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      exc_taken_q <= 1'b0;
      exc_vector_q <= 26'h000_0000;
    end
    else
    begin
      exc_taken_q <= addr_fault || take_fiq || take_irq;
      if (addr_fault || take_fiq || take_irq)
      begin
        exc_vector_q <= {r15_d[`MBE_PC_HI:`MBE_PC_LO], 2'b00};
      end
    end
  end

  // Mode pins follow the mode the next cycle runs in; the translate hint tests that mode for user and the current mode for supervisor
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_n_q <= 2'b00;
      translate_hint_n_n_q <= 1'b1;
    end
    else
    begin
      mode_n_q <= ~mode_d; // see RULE17
      translate_hint_n_n_q <= !(mode_d == mbe_pkg::MBE_MODE_USER
        || (mode == mbe_pkg::MBE_MODE_SVC && xfer_valid && xfer_kind == mbe_pkg::MBE_XF_SINGLE
        && xfer_force_translate_hint_n && !addr_fault)); // see RULE16
    end
  end

  assign rd_data = rd_data_q;
  assign addr_out = addr_out_q;
  assign store_lanes = store_lanes_q;
  assign store_byte = store_byte_q;
  assign exc_taken = exc_taken_q;
  assign exc_vector = exc_vector_q;
  assign status_flags = r15_q;
  assign mode_code_out_n = mode_n_q;
  assign translate_hint_n = translate_hint_n_n_q;

endmodule : mbe_core

// ==== sim/mbe_irq_src.sv ====
/* Interrupt sources facing the core: two active-low request pins.
   Assumes the bench sets the request levels off the clock edge. */
`timescale 1ns/1ps
module mbe_irq_src (
  input wire logic fiq_on, // Raise fast request
  input wire logic irq_on, // Raise normal request
  output logic fiq_req_n, // Fast pin
  output logic irq_req_n // Normal pin
);
  // Levels stay low for as long as the bench holds fiq_on and irq_on, as a real source must
  assign fiq_req_n = ~fiq_on;
  assign irq_req_n = ~irq_on;
endmodule : mbe_irq_src

// ==== sim/mbe_core_sva.sv ====
/* Checker for mbe_core: mode pins, traps and interrupt entry.
   Assumes it is bound to every mbe_core instance. */
`timescale 1ns/1ps
module mbe_core_sva (
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic instr_boundary, // Boundary
  input wire logic xfer_valid, // Transfer
  input wire mbe_pkg::mbe_xfer_t xfer_kind, // Kind
  input wire logic xfer_first, // First word
  input wire logic [31:0] xfer_addr, // Address
  input wire logic exc_taken, // Entry pulse
  input wire logic [25:0] exc_vector, // Vector
  input wire logic [31:0] status_flags, // Register fifteen
  input wire logic [1:0] mode_code_out_n, // Mode pins
  input wire logic translate_hint_n // Hint
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [1:0] md;
  logic fault;
  assign md = status_flags[1:0];
  assign fault = xfer_valid && |xfer_addr[31:26] && (xfer_kind == mbe_pkg::MBE_XF_SINGLE
    || (xfer_kind == mbe_pkg::MBE_XF_BLOCK && xfer_first));
  a_mode_pins: assert property (mode_code_out_n == ~md)
    else $error("mode pins differ");
  a_fiq_entry: assert property (exc_taken && exc_vector == 26'h000_001C |-> md == 2'h1
    && status_flags[27:26] == 2'h3 && status_flags[25:2] == 24'h00_0007) else $error("fast entry");
  a_irq_entry: assert property (exc_taken && exc_vector == 26'h000_0018 |-> md == 2'h2
    && status_flags[27] && status_flags[25:2] == 24'h00_0006) else $error("normal entry");
  a_addr_trap: assert property (fault |=> exc_taken && exc_vector == 26'h000_0014
    && md == 2'h3 && status_flags[27]) else $error("address trap");
  a_no_trap: assert property (xfer_valid && !fault && !instr_boundary |=> !exc_taken)
    else $error("spurious trap");
  a_user_locked: assert property (md == 2'h0 |=> exc_taken
    || (md == 2'h0 && $stable(status_flags[27:26]))) else $error("user changed masks");
  a_user_hint: assert property (md == 2'h0 |-> !translate_hint_n)
    else $error("hint high in user");
  a_fiq_masked: assert property (exc_taken && exc_vector == 26'h000_001C |-> !$past(status_flags[26]))
    else $error("fast taken masked");
  a_irq_masked: assert property (exc_taken && exc_vector == 26'h000_0018 |-> !$past(status_flags[27]))
    else $error("normal taken masked");
  c_fiq: cover property (exc_taken && exc_vector == 26'h000_001C);
  c_irq: cover property (exc_taken && exc_vector == 26'h000_0018);
  c_trap: cover property (exc_taken && exc_vector == 26'h000_0014);
endmodule : mbe_core_sva
bind mbe_core mbe_core_sva i_mbe_core_sva (.*);

// ==== sim/tb_mbe_core.sv ====
/* Bench for mbe_core: banking, status writes, traps and interrupts.
   Assumes mbe_irq_src drives the interrupt pins. */
`timescale 1ns/1ps
module tb_mbe_core;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic fiq_on = 1'h0;
  logic irq_on = 1'h0;
  logic fiq_req_n, irq_req_n, exc_taken, translate_hint_n;
  logic instr_boundary = 1'h0, wr_en = 1'h0, wr_pc_sel = 1'h0, wr_psr_sel = 1'h0, link_en = 1'h0;
  logic xfer_valid = 1'h0, xfer_first = 1'h0, xfer_byte = 1'h0, xfer_force_translate_hint_n = 1'h0;
  logic [3:0] rd_idx = 4'h0, wr_idx = 4'h0;
  logic [31:0] wr_data = 32'h0, xfer_addr = 32'h0, store_word = 32'h0;
  logic [31:0] rd_data, store_lanes, status_flags;
  mbe_pkg::mbe_xfer_t xfer_kind = mbe_pkg::MBE_XF_SINGLE;
  logic [25:0] addr_out, exc_vector;
  logic [7:0] store_byte;
  logic [1:0] mode_code_out_n;
  int err_count = 0;
  int checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  mbe_irq_src i_mbe_irq_src (.*);
  mbe_core i_mbe_core (.*);
  task automatic close_out;
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Each strobe task lets one idle edge pass first, so back-to-back calls never re-raise a strobe in one step
  task automatic wreg(input logic [3:0] i, input logic [31:0] d, input logic pc, input logic ps);
    @(negedge clk_sys);
    wr_en = 1'h1;
    wr_idx = i;
    wr_data = d;
    wr_pc_sel = pc;
    wr_psr_sel = ps;
    @(negedge clk_sys);
    wr_en = 1'h0;
  endtask : wreg
  task automatic rreg(input logic [3:0] i, input logic [31:0] e);
    rd_idx = i;
    @(negedge clk_sys);
    chk(rd_data, e);
  endtask : rreg
  task automatic xfer(input mbe_pkg::mbe_xfer_t k, input logic f, input logic [31:0] a);
    @(negedge clk_sys);
    xfer_valid = 1'h1;
    xfer_kind = k;
    xfer_first = f;
    xfer_addr = a;
    @(negedge clk_sys);
    xfer_valid = 1'h0;
  endtask : xfer
  task automatic bnd;
    @(negedge clk_sys);
    instr_boundary = 1'h1;
    @(negedge clk_sys);
    instr_boundary = 1'h0;
  endtask : bnd
  // Entry pulse lasts one cycle, so poll it at every falling edge
  task automatic wexc(input logic [25:0] v);
    int n;
    n = 0;
    while (exc_taken !== 1'h1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk({6'h0, exc_vector}, {6'h0, v});
    if (n == 8)
    begin
      err_count++;
      $display("[ERR] %0t no exception entry seen", $time);
      close_out();
    end
  endtask : wexc
  initial
  begin
    repeat (6) @(negedge clk_sys);
    rst = 1'h0;
    chk(status_flags, 32'h0C00_0003);
    chk({29'h0, mode_code_out_n, translate_hint_n}, 32'h1);
    wreg(4'hD, 32'hAAAA_0001, 1'h0, 1'h0);
    wreg(4'hE, 32'hBBBB_0002, 1'h0, 1'h0);
    wreg(4'h8, 32'hCCCC_0003, 1'h0, 1'h0);
    wreg(4'hF, 32'hF000_0000, 1'h0, 1'h1);
    chk(status_flags, 32'hF000_0000);
    rreg(4'hD, 32'h0);
    rreg(4'hE, 32'h0);
    rreg(4'h8, 32'hCCCC_0003);
    chk({29'h0, mode_code_out_n, translate_hint_n}, 32'h6);
    wreg(4'hF, 32'h0C00_0003, 1'h0, 1'h1);
    chk(status_flags, 32'h0);
    wreg(4'hF, 32'h0000_0100, 1'h1, 1'h0);
    link_en = 1'h1;
    @(negedge clk_sys);
    link_en = 1'h0;
    rreg(4'hE, 32'h0000_0100);
    xfer(mbe_pkg::MBE_XF_BRANCH, 1'h0, 32'hFC00_0000);
    chk({31'h0, exc_taken}, 32'h0);
    xfer(mbe_pkg::MBE_XF_BLOCK, 1'h0, 32'h0400_0000);
    chk({31'h0, exc_taken}, 32'h0);
    xfer(mbe_pkg::MBE_XF_SINGLE, 1'h0, 32'h0400_0000);
    wexc(26'h000_0014);
    chk(status_flags, 32'h0800_0017);
    rreg(4'hE, 32'h0000_0100);
    rreg(4'hD, 32'hAAAA_0001);
    xfer(mbe_pkg::MBE_XF_BLOCK, 1'h1, 32'h8000_0000);
    wexc(26'h000_0014);
    xfer_byte = 1'h1;
    xfer_force_translate_hint_n = 1'h1;
    store_word = 32'h4433_2211;
    xfer(mbe_pkg::MBE_XF_SINGLE, 1'h0, 32'h0000_0001);
    chk({24'h0, store_byte}, 32'h22);
    chk({6'h0, addr_out}, 32'h1);
    chk({31'h0, translate_hint_n}, 32'h0);
    xfer_byte = 1'h0;
    xfer_force_translate_hint_n = 1'h0;
    xfer(mbe_pkg::MBE_XF_SINGLE, 1'h0, 32'h0000_0007);
    chk({6'h0, addr_out}, 32'h4);
    chk(store_lanes, 32'h4433_2211);
    chk({31'h0, translate_hint_n}, 32'h1);
    wreg(4'hF, 32'h0000_0003, 1'h0, 1'h1);
    fiq_on = 1'h1;
    irq_on = 1'h1;
    repeat (5) @(negedge clk_sys);
    bnd();
    wexc(26'h000_001C);
    chk(status_flags, 32'h0C00_001D);
    rreg(4'hE, 32'h0000_0017);
    rreg(4'h8, 32'h0);
    rreg(4'hD, 32'h0);
    bnd();
    chk({31'h0, exc_taken}, 32'h0);
    wreg(4'hF, 32'h0400_0001, 1'h0, 1'h1);
    bnd();
    wexc(26'h000_0018);
    chk(status_flags, 32'h0C00_001A);
    rreg(4'hE, 32'h0400_001D);
    rreg(4'hD, 32'h0);
    chk({29'h0, mode_code_out_n, translate_hint_n}, 32'h3);
    fiq_on = 1'h0;
    irq_on = 1'h0;
    close_out();
  end
endmodule : tb_mbe_core
